// *** essg_guard.sv ***
`default_nettype none
// Top level: enclave mode tracking, control-flow state swap, checks and faults.
module essg_guard
	import essg_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// Mode transitions.
	input  wire logic                        enterReq,
	input  wire logic                        resumeReq,
	input  wire logic                        leaveReq,
	input  wire logic                        asyncLeave,
	input  wire logic [essg_pkg::CFG_W-1:0]  hostCfg,
	input  wire logic [essg_pkg::CFG_W-1:0]  enclaveCfgIn,
	input  wire logic [essg_pkg::CFG_W-1:0]  savedSspIn,
	input  wire logic [essg_pkg::CFG_W-1:0]  curSsp,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeBase,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeLimit,
	output logic                             inEnclave,
	output logic [essg_pkg::CFG_W-1:0]       activeCfg,
	output logic [essg_pkg::CFG_W-1:0]       sspOut,
	output logic                             saveAreaWe,
	output logic [essg_pkg::CFG_W-1:0]       saveAreaData,
	output logic                             savedSspWe,
	output logic [essg_pkg::CFG_W-1:0]       savedSspData,
	// Memory access check.
	input  wire logic                        accValid,
	input  wire essg_pkg::essg_acc_t         accKind,
	input  wire logic [essg_pkg::ADDR_W-1:0] accAddr,
	input  wire logic                        xlatProtected,
	input  wire essg_pkg::essg_page_t        xlatType,
	input  wire logic                        guestWritable,
	input  wire logic                        slatWritable,
	input  wire logic [63:0]                 rdDataIn,
	output logic                             accAllow,
	output logic                             accDone,
	output logic [63:0]                      rdDataOut,
	output logic                             dropWrite,
	// Page operation check.
	input  wire logic                        popValid,
	input  wire essg_pkg::essg_pop_t         popKind,
	input  wire essg_pkg::essg_page_t        popType,
	input  wire logic [essg_pkg::ADDR_W-1:0] popAddr,
	input  wire logic                        paramPresent,
	input  wire logic                        paramReadWrite,
	input  wire logic                        contentZeroExToken,
	input  wire logic                        tokenWordZero,
	input  wire logic [essg_pkg::ADDR_W-1:0] tokenAddr,
	input  wire logic                        savedSspZero,
	output logic                             popDone,
	output logic                             popCommit,
	output essg_pkg::essg_page_t             popEffType,
	output logic                             tokenWe,
	output logic [11:0]                      tokenOffset,
	output logic [essg_pkg::ADDR_W-1:0]      tokenData,
	// Legacy bitmap index after a missed branch target marker.
	input  wire logic                        missedMarker,
	input  wire logic [essg_pkg::ADDR_W-1:0] missAddr,
	output logic [essg_pkg::ADDR_W-essg_pkg::PAGE_SHIFT-1:0] bitmapIndex,
	// Fault report.
	output logic                             faultValid,
	output essg_pkg::essg_fault_t            faultKind,
	output logic [7:0]                       faultCode
);
	import essg_pkg::*;

	// Enclave mode state machine.
	typedef enum logic [1:0] {
		ST_HOST    = 2'b01,
		ST_ENCLAVE = 2'b10
	} essg_mode_t;

	essg_mode_t         mode_q, mode_d;             // Current mode.
	logic [CFG_W-1:0]   scratch_q, scratch_d;       // Host state kept during the enclave.
	logic [CFG_W-1:0]   cfg_q, cfg_d;               // Active control-flow state.
	logic [CFG_W-1:0]   ssp_q, ssp_d;               // Shadow-stack pointer.
	logic               saWe_q, saWe_d;             // Save-area write strobe.
	logic [CFG_W-1:0]   saData_q, saData_d;         // Save-area write data.
	logic               spWe_q, spWe_d;             // Saved pointer field write strobe.
	logic [CFG_W-1:0]   spData_q, spData_d;         // Saved pointer field write data.
	logic               entryBad;                   // Entry request while already inside.
	logic               exitBad;                    // Exit request while outside.
	logic               doEnter;                    // Legal entry this cycle.
	logic               doExit;                     // Legal exit this cycle.

	// Entry only by enter/resume from host mode, exit only by leave/event inside.
	always_comb begin
		doEnter = (mode_q == ST_HOST) && (enterReq || resumeReq);
		doExit = (mode_q == ST_ENCLAVE) && (leaveReq || asyncLeave);
		entryBad = (mode_q == ST_ENCLAVE) && (enterReq || resumeReq);
		exitBad = (mode_q == ST_HOST) && leaveReq;
	end

	// Next mode and state swap values.
	always_comb begin
		mode_d = mode_q;
		scratch_d = scratch_q;
		cfg_d = cfg_q;
		ssp_d = ssp_q;
		saWe_d = 1'b0;
		saData_d = saData_q;
		spWe_d = 1'b0;
		spData_d = spData_q;
		unique case (mode_q)
			ST_HOST: begin
				cfg_d = hostCfg;
				if (doEnter) begin
					scratch_d = hostCfg;
					cfg_d = enclaveCfgIn;
					ssp_d = savedSspIn;
					mode_d = ST_ENCLAVE;
				end
			end
			ST_ENCLAVE: begin
				ssp_d = curSsp;
				if (doExit) begin
					if (asyncLeave) begin
						saWe_d = 1'b1;
						saData_d = cfg_q;
					end
					spWe_d = 1'b1;
					spData_d = curSsp;
					cfg_d = scratch_q;
					mode_d = ST_HOST;
				end
			end
			default: mode_d = ST_HOST;
		endcase
	end

	// Registers the mode and the state swap.
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q <= ST_HOST;
			scratch_q <= '0;
			cfg_q <= '0;
			ssp_q <= '0;
			saWe_q <= 1'b0;
			saData_q <= '0;
			spWe_q <= 1'b0;
			spData_q <= '0;
		end else begin
			mode_q <= mode_d;
			scratch_q <= scratch_d;
			cfg_q <= cfg_d;
			ssp_q <= ssp_d;
			saWe_q <= saWe_d;
			saData_q <= saData_d;
			spWe_q <= spWe_d;
			spData_q <= spData_d;
		end
	end

	// Mode outputs come straight from registers.
	always_comb begin
		inEnclave = (mode_q == ST_ENCLAVE);
		activeCfg = cfg_q;
		sspOut = ssp_q;
		saveAreaWe = saWe_q;
		saveAreaData = saData_q;
		savedSspWe = spWe_q;
		savedSspData = spData_q;
	end

	logic         accOk;       // Access checker verdict.
	logic         accAlter;    // Access from outside to a protected page.
	logic         accIn;       // Access address lies inside the range.
	essg_fault_t  accFault;    // Access checker fault reason.
	logic         popRej;      // Page checker refusal.
	logic         popTok;      // Page checker token request.
	essg_page_t   popEff;      // Effective type after parameter handling.

	// Checks one memory access.
	essg_access_check u_acc (
		.inEnclave     (inEnclave),
		.accKind       (accKind),
		.accAddr       (accAddr),
		.rangeBase     (rangeBase),
		.rangeLimit    (rangeLimit),
		.xlatProtected (xlatProtected),
		.xlatType      (xlatType),
		.guestWritable (guestWritable),
		.slatWritable  (slatWritable),
		.inRange       (accIn),
		.allow         (accOk),
		.fault         (accFault),
		.alterOutside  (accAlter)
	);

	// Checks one page operation.
	essg_page_check u_pop (
		.opKind             (popKind),
		.pageType           (popType),
		.pageAddr           (popAddr),
		.rangeBase          (rangeBase),
		.rangeLimit         (rangeLimit),
		.paramPresent       (paramPresent),
		.paramReadWrite     (paramReadWrite),
		.contentZeroExToken (contentZeroExToken),
		.tokenWordZero      (tokenWordZero),
		.tokenAddr          (tokenAddr),
		.savedSspZero       (savedSspZero),
		.reject             (popRej),
		.effType            (popEff),
		.writeToken         (popTok)
	);

	logic              aDone_q, aDone_d;     // Access answer strobe.
	logic              aAllow_q, aAllow_d;   // Access allowed flag.
	logic [63:0]       rd_q, rd_d;           // Returned read data.
	logic              drop_q, drop_d;       // Write discarded.
	logic              pDone_q, pDone_d;     // Page op answer strobe.
	logic              pCommit_q, pCommit_d; // Page op may update page and map.
	essg_page_t        pType_q, pType_d;     // Type to record.
	logic              tWe_q, tWe_d;         // Token write strobe.
	logic [ADDR_W-1:0] tData_q, tData_d;     // Token value.
	logic              fV_q, fV_d;           // Fault strobe.
	essg_fault_t       fK_q, fK_d;           // Fault reason.
	logic [ADDR_W-PAGE_SHIFT-1:0] bIdx_q, bIdx_d; // Legacy bitmap index.

	// Computes one-cycle answers of accesses, page ops and entry faults.
	always_comb begin
		aDone_d = accValid;
		aAllow_d = accValid && accOk;
		rd_d = accAlter ? READ_ONES : rdDataIn;
		drop_d = accValid && accAlter && (accKind == ACC_STORE || accKind == ACC_SS_STORE);
		pDone_d = popValid;
		pCommit_d = popValid && !popRej;
		pType_d = popEff;
		tWe_d = popValid && popTok;
		tData_d = popAddr + ADDR_W'(PAGE_BYTES);
		bIdx_d = bIdx_q;
		if (missedMarker && inEnclave) begin
			bIdx_d = (ADDR_W-PAGE_SHIFT)'((missAddr - rangeBase) >> PAGE_SHIFT);
		end else if (missedMarker) begin
			bIdx_d = missAddr[ADDR_W-1:PAGE_SHIFT];
		end
		fV_d = 1'b0;
		fK_d = FLT_NONE;
		if (accValid && !accOk) begin
			fV_d = 1'b1;
			fK_d = accFault;
		end else if (popValid && popRej) begin
			fV_d = 1'b1;
			fK_d = FLT_PAGEOP;
		end else if (entryBad || exitBad) begin
			fV_d = 1'b1;
			fK_d = FLT_ENTRY;
		end
	end

	// Registers the answers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			aDone_q <= 1'b0;
			aAllow_q <= 1'b0;
			rd_q <= '0;
			drop_q <= 1'b0;
			pDone_q <= 1'b0;
			pCommit_q <= 1'b0;
			pType_q <= PT_REGULAR;
			tWe_q <= 1'b0;
			tData_q <= '0;
			fV_q <= 1'b0;
			fK_q <= FLT_NONE;
			bIdx_q <= '0;
		end else begin
			aDone_q <= aDone_d;
			aAllow_q <= aAllow_d;
			rd_q <= rd_d;
			drop_q <= drop_d;
			pDone_q <= pDone_d;
			pCommit_q <= pCommit_d;
			pType_q <= pType_d;
			tWe_q <= tWe_d;
			tData_q <= tData_d;
			fV_q <= fV_d;
			fK_q <= fK_d;
			bIdx_q <= bIdx_d;
		end
	end

	// Answer outputs from registers; the token offset and the fault code are constants.
	always_comb begin
		accDone = aDone_q;
		accAllow = aAllow_q;
		rdDataOut = rd_q;
		dropWrite = drop_q;
		popDone = pDone_q;
		popCommit = pCommit_q;
		popEffType = pType_q;
		tokenWe = tWe_q;
		tokenOffset = TOKEN_OFFSET;
		tokenData = tData_q;
		bitmapIndex = bIdx_q;
		faultValid = fV_q;
		faultKind = fK_q;
		faultCode = FAULT_CODE_GP0;
	end

	// Entry saves host state and loads enclave state one edge later.
	property p_entry_swap;
		@(posedge mclk) disable iff (rst)
		doEnter |=> (scratch_q == $past(hostCfg)) && (cfg_q == $past(enclaveCfgIn));
	endproperty
	a_entry_swap: assert property (p_entry_swap) else $error("Entry swap wrong.");

	// Asynchronous leave writes the enclave state to the save area.
	property p_async_save;
		@(posedge mclk) disable iff (rst)
		(doExit && asyncLeave) |=> saveAreaWe && (saveAreaData == $past(cfg_q));
	endproperty
	a_async_save: assert property (p_async_save) else $error("Save area not written.");

	// Any exit restores the host state that was kept at entry.
	property p_exit_restore;
		@(posedge mclk) disable iff (rst)
		doExit |=> (cfg_q == $past(scratch_q)) && !inEnclave;
	endproperty
	a_exit_restore: assert property (p_exit_restore) else $error("Host state lost.");

	// Ordinary stores to shadow pages inside the enclave are refused.
	property p_shadow_store;
		@(posedge mclk) disable iff (rst)
		(accValid && inEnclave && accKind == ACC_STORE && xlatProtected
			&& (xlatType == PT_SHADOW_FIRST || xlatType == PT_SHADOW_LATER))
			|=> accDone && !accAllow && faultValid;
	endproperty
	a_shadow_store: assert property (p_shadow_store) else $error("Store allowed.");

	// Out-of-range shadow access inside the enclave gives a general fault.
	sequence s_ss_outside;
		accValid && inEnclave && !accIn && (accKind == ACC_SS_LOAD || accKind == ACC_SS_STORE);
	endsequence
	property p_ss_range;
		@(posedge mclk) disable iff (rst)
		s_ss_outside |=> faultValid && (faultKind == FLT_GP) && (faultCode == 8'h00);
	endproperty
	a_ss_range: assert property (p_ss_range) else $error("No general fault.");

	// Entry loads the pointer; exit writes the pointer field.
	property p_ssp_field;
		@(posedge mclk) disable iff (rst)
		(doEnter |=> sspOut == $past(savedSspIn)) and
		(doExit |=> savedSspWe && savedSspData == $past(curSsp));
	endproperty
	a_ssp_field: assert property (p_ssp_field) else $error("Pointer field wrong.");

	// Refused page operations never commit and always fault.
	property p_reject;
		@(posedge mclk) disable iff (rst)
		(popValid && popRej) |=> popDone && !popCommit && !tokenWe && faultValid;
	endproperty
	a_reject: assert property (p_reject) else $error("Refused op committed.");

	// A committed first shadow allocate writes the token one page above.
	property p_token;
		@(posedge mclk) disable iff (rst)
		(popValid && !popRej && popKind == OP_DYNAMIC_ALLOC && popEff == PT_SHADOW_FIRST)
			|=> tokenWe && tokenData == $past(popAddr) + ADDR_W'(PAGE_BYTES);
	endproperty
	a_token: assert property (p_token) else $error("Token missing.");

	// Accept-copy, permission-restrict and permission-extend ops on shadow pages are refused.
	property p_no_manage;
		@(posedge mclk) disable iff (rst)
		(popValid && (popType == PT_SHADOW_FIRST || popType == PT_SHADOW_LATER)
			&& (popKind == OP_ACCEPT_COPY || popKind == OP_PERM_RESTRICT
			|| popKind == OP_PERM_EXTEND)) |=> !popCommit;
	endproperty
	a_no_manage: assert property (p_no_manage) else $error("Op allowed on shadow page.");
endmodule
`default_nettype wire

// *** essg_pkg.sv ***
`default_nettype none
package essg_pkg;
	localparam int ADDR_W = 48;               // Linear address width.
	localparam int CFG_W = 64;                // Control-flow state word width.
	localparam logic [11:0] TOKEN_OFFSET = 12'hFF8; // Restore token position in a page.
	localparam logic [12:0] PAGE_BYTES = 13'h1000;  // Page size, 4096 bytes.
	localparam int PAGE_SHIFT = 12;           // Page number starts at this bit.
	localparam logic [63:0] READ_ONES = 64'hFFFFFFFFFFFFFFFF; // Altered read value.
	localparam logic [7:0] FAULT_CODE_GP0 = 8'h00; // General-protection error code.

	// Page types of the enclave page map.
	typedef enum logic [2:0] {
		PT_REGULAR      = 3'h0,
		PT_THREAD_CTRL  = 3'h1,
		PT_SHADOW_FIRST = 3'h2,
		PT_SHADOW_LATER = 3'h3,
		PT_OTHER        = 3'h4
	} essg_page_t;

	// Page operations that software can issue.
	typedef enum logic [2:0] {
		OP_STATIC_ADD      = 3'h0,
		OP_DYNAMIC_ALLOC   = 3'h1,
		OP_ACCEPT          = 3'h2,
		OP_ACCEPT_COPY     = 3'h3,
		OP_PERM_RESTRICT   = 3'h4,
		OP_PERM_EXTEND     = 3'h5
	} essg_pop_t;

	// Memory access kinds.
	typedef enum logic [1:0] {
		ACC_LOAD     = 2'h0,
		ACC_STORE    = 2'h1,
		ACC_SS_LOAD  = 2'h2,
		ACC_SS_STORE = 2'h3
	} essg_acc_t;

	// Fault reasons reported with a fault.
	typedef enum logic [2:0] {
		FLT_NONE   = 3'h0,
		FLT_GP     = 3'h1,
		FLT_PF     = 3'h2,
		FLT_PAGEOP = 3'h3,
		FLT_ENTRY  = 3'h4
	} essg_fault_t;
endpackage
`default_nettype wire

// *** essg_access_check.sv ***
`default_nettype none
// Combinational access checker for one memory access.
module essg_access_check
	import essg_pkg::*;
(
	input  wire logic                    inEnclave,
	input  wire essg_pkg::essg_acc_t     accKind,
	input  wire logic [essg_pkg::ADDR_W-1:0] accAddr,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeBase,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeLimit,
	input  wire logic                    xlatProtected,
	input  wire essg_pkg::essg_page_t    xlatType,
	input  wire logic                    guestWritable,
	input  wire logic                    slatWritable,
	output logic                         inRange,
	output logic                         allow,
	output essg_pkg::essg_fault_t        fault,
	output logic                         alterOutside
);
	logic shadowAcc;  // Access is a shadow-stack load or store.
	logic shadowPage; // Target page has a shadow-stack type.

	// Classifies the access and decides whether it may proceed.
	always_comb begin
		shadowAcc = (accKind == ACC_SS_LOAD) || (accKind == ACC_SS_STORE);
		shadowPage = (xlatType == PT_SHADOW_FIRST) || (xlatType == PT_SHADOW_LATER);
		inRange = (accAddr >= rangeBase) && (accAddr <= rangeLimit);
		fault = FLT_NONE;
		alterOutside = 1'b0;
		if (inEnclave && shadowAcc && !inRange) begin
			fault = FLT_GP;
		end else if (inEnclave && inRange && !xlatProtected) begin
			fault = FLT_PF;
		end else if (inEnclave && xlatProtected && shadowPage && accKind == ACC_STORE) begin
			fault = FLT_PF;
		end else if (inEnclave && inRange && shadowAcc && !shadowPage) begin
			fault = FLT_PF;
		end else if (shadowPage && xlatProtected && !(guestWritable && slatWritable)) begin
			fault = FLT_PF;
		end else if (!inEnclave && xlatProtected) begin
			alterOutside = 1'b1;
		end
		allow = (fault == FLT_NONE);
	end
endmodule
`default_nettype wire

// *** essg_page_check.sv ***
`default_nettype none
// Combinational checker for page-build and page-management operations.
module essg_page_check
	import essg_pkg::*;
(
	input  wire essg_pkg::essg_pop_t     opKind,
	input  wire essg_pkg::essg_page_t    pageType,
	input  wire logic [essg_pkg::ADDR_W-1:0] pageAddr,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeBase,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeLimit,
	input  wire logic                    paramPresent,
	input  wire logic                    paramReadWrite,
	input  wire logic                    contentZeroExToken,
	input  wire logic                    tokenWordZero,
	input  wire logic [essg_pkg::ADDR_W-1:0] tokenAddr,
	input  wire logic                    savedSspZero,
	output logic                         reject,
	output essg_pkg::essg_page_t         effType,
	output logic                         writeToken
);
	logic shadowPage;  // Effective type is a shadow-stack type.
	logic edgePage;    // Page is the lowest or highest page of the range.
	logic [ADDR_W-1:0] nextPage; // Page address plus one page.

	// Evaluates every refusal condition of the operation.
	always_comb begin
		nextPage = pageAddr + ADDR_W'(PAGE_BYTES);
		effType = pageType;
		if (opKind == OP_DYNAMIC_ALLOC && !paramPresent) begin
			effType = PT_REGULAR;
		end
		shadowPage = (effType == PT_SHADOW_FIRST) || (effType == PT_SHADOW_LATER);
		edgePage = (pageAddr[ADDR_W-1:PAGE_SHIFT] == rangeBase[ADDR_W-1:PAGE_SHIFT])
			|| (pageAddr[ADDR_W-1:PAGE_SHIFT] == rangeLimit[ADDR_W-1:PAGE_SHIFT]);
		reject = 1'b0;
		writeToken = 1'b0;
		unique case (opKind)
			OP_STATIC_ADD: begin
				if (shadowPage && edgePage) reject = 1'b1;
				if (effType == PT_SHADOW_LATER && !(contentZeroExToken && tokenWordZero))
					reject = 1'b1;
				if (effType == PT_SHADOW_FIRST && !(contentZeroExToken && tokenAddr == nextPage))
					reject = 1'b1;
				if (effType == PT_THREAD_CTRL && !savedSspZero) reject = 1'b1;
			end
			OP_DYNAMIC_ALLOC: begin
				if (shadowPage && edgePage) reject = 1'b1;
				if (shadowPage && !paramReadWrite) reject = 1'b1;
				writeToken = !reject && (effType == PT_SHADOW_FIRST);
			end
			OP_ACCEPT: begin
				if (effType == PT_THREAD_CTRL && !savedSspZero) reject = 1'b1;
			end
			OP_ACCEPT_COPY, OP_PERM_RESTRICT, OP_PERM_EXTEND: begin
				if (shadowPage) reject = 1'b1;
			end
			default: reject = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// *** essg_soft_model.sv ***
`default_nettype none
// Page-table and memory model that software sets up around the enclave range.
module essg_soft_model
	import essg_pkg::*;
(
	input  wire logic [essg_pkg::ADDR_W-1:0] accAddr,
	input  wire logic [essg_pkg::ADDR_W-1:0] rangeBase,
	output logic                             xlatProtected,
	output essg_pkg::essg_page_t             xlatType,
	output logic                             guestWritable,
	output logic                             slatWritable,
	output logic [63:0]                      rdDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ADDR_W-1:0] pg; // Page number relative to the range base.
	// Page 1 first shadow, 2, 3 and 6 later shadow, 5 unprotected, others regular.
	always_comb begin
		pg = (accAddr - rangeBase) >> PAGE_SHIFT;
		xlatProtected = (pg != 48'h5);
		xlatType = (pg == 48'h1) ? PT_SHADOW_FIRST : PT_REGULAR;
		if (pg == 48'h2 || pg == 48'h3 || pg == 48'h6) begin
			xlatType = PT_SHADOW_LATER;
		end
		// Page 3 is left read-only in the guest tables on purpose.
		guestWritable = (pg != 48'h3);
		// Page 6 is left read-only in the second-level tables on purpose.
		slatWritable = (pg != 48'h6);
		// Memory data changes with the address so a stale value never matches.
		rdDataIn = {16'h0, ~accAddr};
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
// Self-checking bench for the shadow-stack guard.
module testbench
	import essg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [47:0] B = 48'h10000; // Enclave range base.
	logic mclk = 0, rst = 1, enterReq = 0, resumeReq = 0, leaveReq = 0, asyncLeave = 0;
	logic accValid = 0, popValid = 0, paramPresent = 0, paramReadWrite = 0, missedMarker = 0;
	logic contentZeroExToken = 0, tokenWordZero = 0, savedSspZero = 0;
	logic [63:0] hostCfg = 64'hA5A5, enclaveCfgIn = 64'hC3C3, savedSspIn = 64'h7000, curSsp = 0;
	logic [47:0] rangeBase = B, rangeLimit = 48'h1FFFF, accAddr = 0, popAddr = 0;
	logic [47:0] tokenAddr = 0, missAddr = 0, tokenData;
	essg_acc_t accKind = ACC_LOAD;
	essg_pop_t popKind = OP_STATIC_ADD;
	essg_page_t popType = PT_REGULAR, popEffType, xlatType;
	essg_fault_t faultKind;
	logic inEnclave, saveAreaWe, savedSspWe, accAllow, accDone, dropWrite, popDone, popCommit;
	logic tokenWe, faultValid, xlatProtected, guestWritable, slatWritable;
	logic [63:0] activeCfg, sspOut, saveAreaData, savedSspData, rdDataOut, rdDataIn;
	logic [11:0] tokenOffset;
	logic [35:0] bitmapIndex;
	logic [7:0] faultCode;
	int n_mismatch = 0, compares = 0, cycles = 0;
	essg_guard essg_guard_i (.mclk, .rst, .enterReq, .resumeReq, .leaveReq, .asyncLeave,
		.hostCfg, .enclaveCfgIn, .savedSspIn, .curSsp, .rangeBase, .rangeLimit, .inEnclave,
		.activeCfg, .sspOut, .saveAreaWe, .saveAreaData, .savedSspWe, .savedSspData, .accValid,
		.accKind, .accAddr, .xlatProtected, .xlatType, .guestWritable, .slatWritable, .rdDataIn,
		.accAllow, .accDone, .rdDataOut, .dropWrite, .popValid, .popKind, .popType, .popAddr,
		.paramPresent, .paramReadWrite, .contentZeroExToken, .tokenWordZero, .tokenAddr,
		.savedSspZero, .popDone, .popCommit, .popEffType, .tokenWe, .tokenOffset, .tokenData,
		.missedMarker, .missAddr, .bitmapIndex, .faultValid, .faultKind, .faultCode);
	essg_soft_model essg_soft_model_i (.accAddr, .rangeBase, .xlatProtected, .xlatType,
		.guestWritable, .slatWritable, .rdDataIn);
	// Free-running clock, 10 ns period.
	always #5 mclk = ~mclk;
	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			test_done();
		end
	end
	// Compares one value and reports a mismatch.
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One-cycle pulse on enter, resume, leave or asynchronous leave; answer is one edge on.
	task automatic mode(input logic [3:0] m);
		@(posedge mclk);
		{enterReq, resumeReq, leaveReq, asyncLeave} <= m;
		@(posedge mclk);
		{enterReq, resumeReq, leaveReq, asyncLeave} <= 4'h0;
		#1;
	endtask
	// Issues one access and checks the verdict.
	task automatic accChk(input essg_acc_t k, input logic [47:0] a, input logic ok,
		input essg_fault_t f);
		@(posedge mclk);
		accKind <= k;
		accAddr <= a;
		accValid <= 1'h1;
		@(posedge mclk);
		accValid <= 1'h0;
		#1;
		chk("accDone", 1'h1, accDone);
		chk("accAllow", ok, accAllow);
		chk("faultValid", !ok, faultValid);
		// A kind of none means the kind is not checked.
		if (f != FLT_NONE) begin
			chk("faultKind", f, faultKind);
			chk("faultCode", FAULT_CODE_GP0, faultCode);
		end
	endtask
	// Issues one page operation; fl packs the five page-context flags.
	task automatic popChk(input essg_pop_t k, input essg_page_t t, input logic [47:0] a,
		input logic [4:0] fl, input logic [47:0] ta, input logic ok);
		@(posedge mclk);
		popKind <= k;
		popType <= t;
		popAddr <= a;
		tokenAddr <= ta;
		{paramPresent, paramReadWrite, contentZeroExToken, tokenWordZero, savedSspZero} <= fl;
		popValid <= 1'h1;
		@(posedge mclk);
		popValid <= 1'h0;
		#1;
		chk("popDone", 1'h1, popDone);
		chk("popCommit", ok, popCommit);
		chk("faultValid", !ok, faultValid);
	endtask
	// Main sequence: page building, entry, accesses, exits.
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'h0;
		popChk(OP_STATIC_ADD, PT_SHADOW_FIRST, B, 5'h06, B + 48'h1000, 1'h0);
		popChk(OP_DYNAMIC_ALLOC, PT_SHADOW_LATER, 48'h1F000, 5'h18, 0, 1'h0);
		popChk(OP_DYNAMIC_ALLOC, PT_SHADOW_FIRST, B + 48'h4000, 5'h18, 0, 1'h1);
		chk("tokenWe", 1'h1, tokenWe);
		chk("tokenOffset", 12'hFF8, tokenOffset);
		chk("tokenData", B + 48'h5000, tokenData);
		popChk(OP_DYNAMIC_ALLOC, PT_SHADOW_FIRST, B + 48'h4000, 5'h10, 0, 1'h0);
		popChk(OP_DYNAMIC_ALLOC, PT_SHADOW_LATER, B + 48'h4000, 5'h00, 0, 1'h1);
		chk("popEffType", PT_REGULAR, popEffType);
		popChk(OP_STATIC_ADD, PT_SHADOW_LATER, B + 48'h2000, 5'h04, 0, 1'h0);
		popChk(OP_STATIC_ADD, PT_SHADOW_LATER, B + 48'h2000, 5'h06, 0, 1'h1);
		popChk(OP_STATIC_ADD, PT_SHADOW_FIRST, B + 48'h1000, 5'h04, B + 48'h2000, 1'h1);
		popChk(OP_STATIC_ADD, PT_SHADOW_FIRST, B + 48'h1000, 5'h04, B + 48'h1000, 1'h0);
		popChk(OP_STATIC_ADD, PT_SHADOW_FIRST, B + 48'h1000, 5'h00, B + 48'h2000, 1'h0);
		popChk(OP_STATIC_ADD, PT_THREAD_CTRL, B + 48'h6000, 5'h06, 0, 1'h0);
		popChk(OP_ACCEPT, PT_THREAD_CTRL, B + 48'h6000, 5'h07, 0, 1'h1);
		for (int k = 3; k <= 5; k++) begin
			popChk(essg_pop_t'(k), PT_SHADOW_LATER, B + 48'h2000, 5'h07, 0, 1'h0);
		end
		mode(4'h8);
		chk("inEnclave", 1'h1, inEnclave);
		chk("activeCfg", 64'hC3C3, activeCfg);
		chk("sspOut", 64'h7000, sspOut);
		@(posedge mclk);
		hostCfg <= 64'h1111;
		curSsp <= 64'h7FF0;
		accChk(ACC_SS_STORE, B + 48'h1008, 1'h1, FLT_NONE);
		accChk(ACC_SS_LOAD, B + 48'h2010, 1'h1, FLT_NONE);
		accChk(ACC_LOAD, B + 48'h2010, 1'h1, FLT_NONE);
		accChk(ACC_STORE, B + 48'h1008, 1'h0, FLT_PF);
		accChk(ACC_SS_STORE, B + 48'h3000, 1'h0, FLT_PF);
		accChk(ACC_SS_LOAD, B + 48'h6000, 1'h0, FLT_PF);
		accChk(ACC_SS_LOAD, 48'h5000, 1'h0, FLT_GP);
		accChk(ACC_LOAD, B + 48'h5000, 1'h0, FLT_PF);
		mode(4'h8);
		chk("faultKind", FLT_ENTRY, faultKind);
		mode(4'h1);
		chk("inEnclave", 1'h0, inEnclave);
		chk("activeCfg", 64'hA5A5, activeCfg);
		chk("saveAreaWe", 1'h1, saveAreaWe);
		chk("saveAreaData", 64'hC3C3, saveAreaData);
		chk("savedSspData", 64'h7FF0, savedSspData);
		accChk(ACC_LOAD, B + 48'h4000, 1'h1, FLT_NONE);
		chk("rdDataOut", READ_ONES, rdDataOut);
		accChk(ACC_STORE, B + 48'h4000, 1'h1, FLT_NONE);
		chk("dropWrite", 1'h1, dropWrite);
		mode(4'h4);
		chk("inEnclave", 1'h1, inEnclave);
		@(posedge mclk);
		missedMarker <= 1'h1;
		missAddr <= B + 48'h3123;
		@(posedge mclk);
		missedMarker <= 1'h0;
		#1;
		chk("bitmapIndex", 36'h3, bitmapIndex);
		mode(4'h2);
		chk("savedSspWe", 1'h1, savedSspWe);
		chk("activeCfg", 64'h1111, activeCfg);
		// Outside the enclave the bitmap index is the absolute page number.
		@(posedge mclk);
		missedMarker <= 1'h1;
		@(posedge mclk);
		missedMarker <= 1'h0;
		#1;
		chk("bitmapIndex", 36'h13, bitmapIndex);
		mode(4'h2);
		chk("faultKind", FLT_ENTRY, faultKind);
		test_done();
	end
endmodule
`default_nettype wire
